// *** include/osp_pkg.sv ***
// Constants and types of the optical sensor serial port and motion logic
package osp_pkg;
	// ************************************************************
	// Clock and timing
	// ************************************************************
	localparam int CLK_MHZ = 125;
	localparam int CW = 40;
	localparam longint RUN_PER_US = 1000;
	localparam longint REST1_PER_US = 16500;
	localparam longint REST2_PER_US = 82000;
	localparam longint REST3_PER_US = 410000;
	localparam longint DOWN1_US = 237000;
	localparam longint DOWN2_US = 8400000;
	localparam longint DOWN3_US = 504000000;
	localparam int LED_ON_NS = 200;
	localparam logic [CW-1:0] RUN_PER_CYC = CW'(RUN_PER_US * CLK_MHZ);
	localparam logic [CW-1:0] REST1_PER_CYC = CW'(REST1_PER_US * CLK_MHZ);
	localparam logic [CW-1:0] REST2_PER_CYC = CW'(REST2_PER_US * CLK_MHZ);
	localparam logic [CW-1:0] REST3_PER_CYC = CW'(REST3_PER_US * CLK_MHZ);
	localparam logic [CW-1:0] DOWN1_CYC = CW'(DOWN1_US * CLK_MHZ);
	localparam logic [CW-1:0] DOWN2_CYC = CW'(DOWN2_US * CLK_MHZ);
	localparam logic [CW-1:0] DOWN3_CYC = CW'(DOWN3_US * CLK_MHZ);
	localparam logic [7:0] LED_CYC = 8'(LED_ON_NS * CLK_MHZ / 1000);
	// ************************************************************
	// Register addresses and fields
	// ************************************************************
	localparam logic [6:0] ADDR_MOTION = 7'h02;
	localparam logic [6:0] ADDR_DY = 7'h03;
	localparam logic [6:0] ADDR_DX = 7'h04;
	localparam logic [6:0] ADDR_SQ = 7'h05;
	localparam logic [6:0] ADDR_SHUT_HI = 7'h06;
	localparam logic [6:0] ADDR_SHUT_LO = 7'h07;
	localparam logic [6:0] ADDR_PEAK = 7'h08;
	localparam logic [6:0] ADDR_BURST = 7'h42;
	localparam logic [2:0] BURST_LAST = 3'h6;
	localparam int DIR_BIT = 7;
	localparam int MOT_BIT = 7;
	localparam logic [2:0] BIT_LAST = 3'h7;
	// ************************************************************
	// Types
	// ************************************************************
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_WDATA = 3'b010,
		ST_RDATA = 3'b011,
		ST_LOCK = 3'b100
	} osp_state_t;
	typedef enum logic [1:0] {
		LV_RUN = 2'b00,
		LV_REST1 = 2'b01,
		LV_REST2 = 2'b10,
		LV_REST3 = 2'b11
	} osp_rest_t;
	typedef struct packed {
		logic [7:0] dy;
		logic [7:0] dx;
		logic [7:0] surface_quality;
		logic [7:0] shut_hi;
		logic [7:0] shut_lo;
		logic [7:0] peak;
	} osp_frame_t;
endpackage : osp_pkg

// *** src/osp_serial_port.sv ***
// Serial port slave, motion flag, rest levels and light flashing
module osp_serial_port import osp_pkg::*; #(
	parameter logic [CW-1:0] P_RUN_PER = RUN_PER_CYC,
	parameter logic [CW-1:0] P_PER1 = REST1_PER_CYC,
	parameter logic [CW-1:0] P_PER2 = REST2_PER_CYC,
	parameter logic [CW-1:0] P_PER3 = REST3_PER_CYC,
	parameter logic [CW-1:0] P_DOWN1 = DOWN1_CYC,
	parameter logic [CW-1:0] P_DOWN2 = DOWN2_CYC,
	parameter logic [CW-1:0] P_DOWN3 = DOWN3_CYC
) (
	input wire logic I_CLK,
	input wire logic I_SYS_RST,
	input wire logic I_CE,
	input wire logic I_SCLK,
	input wire logic I_MOSI,
	input wire logic I_NCS,
	input wire logic I_FRAME_VALID,
	input wire osp_frame_t I_FRAME,
	output logic O_MISO,
	output logic O_MISO_OE,
	output logic O_MOTION_N,
	output logic O_LED,
	output logic O_CAPTURE,
	output logic [1:0] O_REST_LEVEL
);
	// ************************************************************
	// Pin synchronisers
	// ************************************************************
	logic [2:0] sclk_s;
	logic [1:0] mosi_s;
	logic [1:0] ncs_s;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_act;

	// Two flops per pin; third sclk stage only for edge finding
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			sclk_s <= 3'h0;
			mosi_s <= 2'h0;
			ncs_s <= 2'h3;
		end else if (I_CE) begin
			sclk_s <= {sclk_s[1:0], I_SCLK};
			mosi_s <= {mosi_s[0], I_MOSI};
			ncs_s <= {ncs_s[0], I_NCS};
		end
	end
	// Edges qualified by select so a shared bus is ignored
	assign cs_act = ~ncs_s[1];
	assign sclk_rise = cs_act & sclk_s[1] & ~sclk_s[2];
	assign sclk_fall = cs_act & ~sclk_s[1] & sclk_s[2];

	// ************************************************************
	// Register storage and read mux
	// ************************************************************
	logic [7:0] mem [0:127];
	logic [7:0] acc_dx;
	logic [7:0] acc_dy;
	logic mot_flag;
	osp_frame_t frame_q;
	logic wr_en;
	logic [6:0] wr_addr;
	logic [7:0] wr_data;

	// Read value of one address; plain registers come from storage
	function automatic logic [7:0] rd_val(input logic [6:0] a);
		logic [7:0] v;
		v = mem[a];
		case (a)
			ADDR_MOTION: v = 8'(mot_flag) << MOT_BIT;
			ADDR_DY: v = acc_dy;
			ADDR_DX: v = acc_dx;
			ADDR_SQ: v = frame_q.surface_quality;
			ADDR_SHUT_HI: v = frame_q.shut_hi;
			ADDR_SHUT_LO: v = frame_q.shut_lo;
			ADDR_PEAK: v = frame_q.peak;
			default: v = mem[a];
		endcase
		return v;
	endfunction : rd_val

	// Storage has no reset: contents are undefined until written
	always_ff @(posedge I_CLK) begin
		if (I_CE && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// ************************************************************
	// Serial port state machine
	// ************************************************************
	osp_state_t st;
	osp_state_t next_st;
	logic [2:0] bcnt;
	logic [2:0] next_bcnt;
	logic [7:0] sh;
	logic [7:0] next_sh;
	logic [7:0] tx;
	logic [7:0] next_tx;
	logic [6:0] addr;
	logic [6:0] next_addr;
	logic burst;
	logic next_burst;
	logic [2:0] bidx;
	logic [2:0] next_bidx;
	logic next_miso;
	logic next_oe;
	logic load;
	logic [6:0] load_addr;
	logic [7:0] rx_byte;

	assign rx_byte = {sh[6:0], mosi_s[1]};

	// Shift on rise, present on fall; select high resets state, bit count and burst flag
	always_comb begin
		next_st = st;
		next_bcnt = bcnt;
		next_sh = sh;
		next_tx = tx;
		next_addr = addr;
		next_burst = burst;
		next_bidx = bidx;
		next_miso = O_MISO;
		load = 1'b0;
		load_addr = addr;
		wr_en = 1'b0;
		wr_addr = addr;
		wr_data = rx_byte;
		case (st)
			ST_IDLE: begin
				next_bcnt = 3'h0;
				if (cs_act) begin
					next_st = ST_ADDR;
				end
			end
			ST_ADDR: begin
				if (sclk_rise) begin
					next_sh = rx_byte;
					next_bcnt = bcnt + 3'h1;
					if (bcnt == BIT_LAST) begin
						next_addr = rx_byte[6:0];
						next_burst = 1'b0;
						if (rx_byte[DIR_BIT]) begin
							next_st = ST_WDATA;
						end else begin
							next_st = ST_RDATA;
							load = 1'b1;
							next_bidx = 3'h0;
							next_burst = rx_byte[6:0] == ADDR_BURST;
							load_addr = next_burst ? ADDR_MOTION
								: rx_byte[6:0];
							next_tx = rd_val(load_addr);
						end
					end
				end
			end
			ST_WDATA: begin
				if (sclk_rise) begin
					next_sh = rx_byte;
					next_bcnt = bcnt + 3'h1;
					if (bcnt == BIT_LAST) begin
						wr_en = 1'b1;
						next_st = ST_ADDR;
					end
				end
			end
			ST_RDATA: begin
				if (sclk_fall) begin
					next_miso = tx[7];
					next_tx = {tx[6:0], 1'b0};
				end else if (sclk_rise) begin
					next_bcnt = bcnt + 3'h1;
					if (bcnt == BIT_LAST) begin
						if (burst && bidx != BURST_LAST) begin
							next_bidx = bidx + 3'h1;
							load = 1'b1;
							load_addr = ADDR_MOTION + 7'(next_bidx);
							next_tx = rd_val(load_addr);
						end else if (burst) begin
							next_st = ST_LOCK;
						end else begin
							next_st = ST_ADDR;
						end
					end
				end
			end
			ST_LOCK: begin
				next_st = ST_LOCK;
			end
			default: begin
				next_st = ST_IDLE;
			end
		endcase
		if (!cs_act) begin
			next_st = ST_IDLE;
			next_bcnt = 3'h0;
			next_burst = 1'b0;
		end
		// Output driven only while a read answers; never self-started
		next_oe = cs_act && next_st == ST_RDATA;
	end

	// Port state registers
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			st <= ST_IDLE;
			bcnt <= 3'h0;
			sh <= 8'h00;
			tx <= 8'h00;
			addr <= 7'h00;
			burst <= 1'b0;
			bidx <= 3'h0;
			O_MISO <= 1'b0;
			O_MISO_OE <= 1'b0;
		end else if (I_CE) begin
			st <= next_st;
			bcnt <= next_bcnt;
			sh <= next_sh;
			tx <= next_tx;
			addr <= next_addr;
			burst <= next_burst;
			bidx <= next_bidx;
			O_MISO <= next_miso;
			O_MISO_OE <= next_oe;
		end
	end

	// ************************************************************
	// Motion flag, rest levels and light
	// ************************************************************
	logic rd_y;
	logic rd_x;
	logic wr_mot;
	logic moved;
	logic seen_y;
	logic seen_x;
	logic [CW-1:0] idle_cnt;
	logic [CW-1:0] cap_cnt;
	logic [CW-1:0] per;
	logic [7:0] led_cnt;
	logic [7:0] next_acc_dx;
	logic [7:0] next_acc_dy;
	logic next_flag;
	logic next_seen_y;
	logic next_seen_x;
	logic [CW-1:0] next_idle;
	logic [CW-1:0] next_cap;
	logic [7:0] next_led;
	osp_frame_t next_frame;
	osp_rest_t next_rest;
	logic next_capture;

	assign rd_y = load && load_addr == ADDR_DY;
	assign rd_x = load && load_addr == ADDR_DX;
	assign wr_mot = wr_en && wr_addr == ADDR_MOTION;
	assign moved = I_FRAME_VALID && (I_FRAME.dx != 8'h00
		|| I_FRAME.dy != 8'h00);

	// New motion wins over any clear landing in the same cycle
	always_comb begin
		next_frame = I_FRAME_VALID ? I_FRAME : frame_q;
		next_acc_dx = rd_x ? 8'h00 : acc_dx;
		next_acc_dy = rd_y ? 8'h00 : acc_dy;
		next_seen_y = seen_y | rd_y;
		next_seen_x = seen_x | rd_x;
		next_flag = mot_flag;
		if ((next_seen_y && next_seen_x) || wr_mot) begin
			next_flag = 1'b0;
			next_seen_y = 1'b0;
			next_seen_x = 1'b0;
		end
		if (moved) begin
			next_acc_dx = next_acc_dx + I_FRAME.dx;
			next_acc_dy = next_acc_dy + I_FRAME.dy;
			next_flag = 1'b1;
		end
		// Saturating idle time; cleared by reported motion
		next_idle = moved ? '0 : idle_cnt + CW'(idle_cnt != '1);
		if (next_idle >= P_DOWN3) begin
			next_rest = LV_REST3;
		end else if (next_idle >= P_DOWN2) begin
			next_rest = LV_REST2;
		end else if (next_idle >= P_DOWN1) begin
			next_rest = LV_REST1;
		end else begin
			next_rest = LV_RUN;
		end
		case (osp_rest_t'(O_REST_LEVEL))
			LV_REST1: per = P_PER1;
			LV_REST2: per = P_PER2;
			LV_REST3: per = P_PER3;
			default: per = P_RUN_PER;
		endcase
		next_capture = cap_cnt >= per - CW'(1);
		next_cap = next_capture ? '0 : cap_cnt + CW'(1);
		// Light only for a short flash at each capture
		next_led = next_capture ? LED_CYC
			: led_cnt - 8'(led_cnt != 8'h00);
	end

	// Motion and power registers
	always_ff @(posedge I_CLK or posedge I_SYS_RST) begin
		if (I_SYS_RST) begin
			frame_q <= '0;
			acc_dx <= 8'h00;
			acc_dy <= 8'h00;
			mot_flag <= 1'b0;
			seen_y <= 1'b0;
			seen_x <= 1'b0;
			idle_cnt <= '0;
			cap_cnt <= '0;
			led_cnt <= 8'h00;
			O_MOTION_N <= 1'b1;
			O_REST_LEVEL <= LV_RUN;
			O_CAPTURE <= 1'b0;
			O_LED <= 1'b0;
		end else if (I_CE) begin
			frame_q <= next_frame;
			acc_dx <= next_acc_dx;
			acc_dy <= next_acc_dy;
			mot_flag <= next_flag;
			seen_y <= next_seen_y;
			seen_x <= next_seen_x;
			idle_cnt <= next_idle;
			cap_cnt <= next_cap;
			led_cnt <= next_led;
			O_MOTION_N <= ~next_flag;
			O_REST_LEVEL <= next_rest;
			O_CAPTURE <= next_capture;
			O_LED <= next_led != 8'h00;
		end
	end

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge I_CLK); endclocking
	default disable iff (I_SYS_RST);

	property p_cs_idle;
		I_CE && ncs_s[1] |=> st == ST_IDLE && !O_MISO_OE;
	endproperty
	a_cs_idle: assert property (p_cs_idle)
		else $error("port not idle with select high");

	property p_no_start;
		O_MISO_OE |-> $past(cs_act) && st == ST_RDATA;
	endproperty
	a_no_start: assert property (p_no_start)
		else $error("output driven outside a read");

	property p_motion_set;
		I_CE && moved |=> !O_MOTION_N && mot_flag;
	endproperty
	a_motion_set: assert property (p_motion_set)
		else $error("motion output not low after motion");

	property p_motion_wr;
		I_CE && wr_mot && !moved |=> O_MOTION_N;
	endproperty
	a_motion_wr: assert property (p_motion_wr)
		else $error("status write did not clear motion");

	property p_motion_xy;
		I_CE && seen_y && rd_x && !moved |=> O_MOTION_N;
	endproperty
	a_motion_xy: assert property (p_motion_xy)
		else $error("Y then X read did not clear motion");

	property p_led;
		O_LED |-> led_cnt != 8'h00 && led_cnt <= LED_CYC;
	endproperty
	a_led: assert property (p_led)
		else $error("light on beyond its flash");

	property p_rise_shift;
		I_CE && st == ST_ADDR && sclk_rise |=>
			bcnt == 3'($past(bcnt) + 3'h1) && sh[0] == $past(mosi_s[1]);
	endproperty
	a_rise_shift: assert property (p_rise_shift)
		else $error("data in not taken on clock rise");

	property p_fall_out;
		I_CE && st == ST_RDATA && sclk_fall |=> O_MISO == $past(tx[7]);
	endproperty
	a_fall_out: assert property (p_fall_out)
		else $error("output bit wrong after clock fall");

	property p_hold;
		I_CE && !sclk_fall |=> $stable(O_MISO);
	endproperty
	a_hold: assert property (p_hold)
		else $error("output bit changed without clock fall");

	property p_lock;
		I_CE && st == ST_LOCK && cs_act |=> st == ST_LOCK;
	endproperty
	a_lock: assert property (p_lock)
		else $error("burst lock left while selected");

	// Received byte one cycle late, so the check sees the decoded bit
	logic [7:0] rx_byte_q;
	always_ff @(posedge I_CLK) begin
		rx_byte_q <= rx_byte;
	end
	property p_dir;
		I_CE && st == ST_ADDR && sclk_rise && bcnt == BIT_LAST && cs_act
			|=> st == (rx_byte_q[DIR_BIT] ? ST_WDATA : ST_RDATA);
	endproperty
	a_dir: assert property (p_dir)
		else $error("direction bit misdecoded");

	property p_burst;
		load && burst |-> load_addr == ADDR_MOTION + 7'(next_bidx);
	endproperty
	a_burst: assert property (p_burst)
		else $error("burst byte out of order");

	property p_rest;
		idle_cnt >= P_DOWN1 && idle_cnt < P_DOWN2 |-> O_REST_LEVEL == LV_REST1;
	endproperty
	a_rest: assert property (p_rest)
		else $error("rest level one not entered");

	property p_period;
		O_REST_LEVEL == LV_REST1 && I_CE |-> cap_cnt < P_PER1 || per != P_PER1;
	endproperty
	a_period: assert property (p_period)
		else $error("rest one capture period exceeded");

	c_write: cover property (wr_en && I_CE);
	c_burst_end: cover property (st == ST_RDATA ##1 st == ST_LOCK);
	c_abort: cover property (st == ST_RDATA ##1 st == ST_IDLE);
	c_clear: cover property (!O_MOTION_N ##1 O_MOTION_N);
endmodule : osp_serial_port

// *** test/osp_host.sv ***
// Behavioural serial bus master facing the sensor port
module osp_host (
	input wire logic i_clk,
	input wire logic i_miso,
	input wire logic i_miso_oe,
	output logic o_sclk,
	output logic o_mosi,
	output logic o_ncs
);
	timeunit 1ns;
	timeprecision 1ps;
	// Clock idles high and stands still outside frames
	initial begin
		o_sclk = 1'b1;
		o_mosi = 1'b0;
		o_ncs = 1'b1;
	end
	// Half of the 160 ns serial clock, also the minimum high time
	task automatic half();
		repeat (10) @(negedge i_clk);
	endtask : half
	// Shift n bits each way, MSB first; the reply is taken at the rise
	task automatic xfer(input logic [7:0] tx, input int n,
		output logic [7:0] rx);
		rx = 8'h00;
		for (int b = 7; b > 7 - n; b--) begin
			o_sclk = 1'b0;
			o_mosi = tx[b];
			half();
			o_sclk = 1'b1;
			// A released output is not trusted, so it reads inverted
			rx[b] = i_miso_oe ? i_miso : ~i_miso;
			half();
		end
		// Data line no longer meaningful after the byte
		o_mosi = ~o_mosi;
	endtask : xfer
	// Only the master opens a transaction, framed by select
	task automatic sel();
		o_ncs = 1'b0;
		half();
	endtask : sel
	// Release select and keep it high long enough for the next use
	task automatic desel();
		half();
		o_ncs = 1'b1;
		repeat (64) @(negedge i_clk);
	endtask : desel
endmodule : osp_host

// *** test/optical_sensor_serial_port_tb.sv ***
// Self-checking bench for the sensor serial port and motion logic
module optical_sensor_serial_port_tb import osp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	// Short periods and downshift times keep the run brief
	localparam logic [CW-1:0] T_RUN = 40'h28;
	localparam logic [CW-1:0] T_PER1 = 40'h32;
	localparam logic [CW-1:0] T_PER2 = 40'h3c;
	localparam logic [CW-1:0] T_PER3 = 40'h46;
	localparam logic [CW-1:0] T_DOWN1 = 40'h12c;
	localparam logic [CW-1:0] T_DOWN2 = 40'h258;
	localparam logic [CW-1:0] T_DOWN3 = 40'h384;
	logic clk;
	logic rst;
	logic ce;
	logic sclk;
	logic mosi;
	logic ncs;
	logic fv;
	osp_frame_t frame;
	logic miso;
	logic oe;
	logic mot_n;
	logic led;
	logic cap;
	logic [1:0] lvl;
	logic [7:0] d;
	logic [7:0] bx [7];
	time t0;
	int n_errors;
	int total_checks;
	// 125 MHz system clock
	always #4 clk = ~clk;
	osp_serial_port #(
		.P_RUN_PER(T_RUN),
		.P_PER1(T_PER1),
		.P_PER2(T_PER2),
		.P_PER3(T_PER3),
		.P_DOWN1(T_DOWN1),
		.P_DOWN2(T_DOWN2),
		.P_DOWN3(T_DOWN3)
	) osp_serial_port_i (
		.I_CLK(clk),
		.I_SYS_RST(rst),
		.I_CE(ce),
		.I_SCLK(sclk),
		.I_MOSI(mosi),
		.I_NCS(ncs),
		.I_FRAME_VALID(fv),
		.I_FRAME(frame),
		.O_MISO(miso),
		.O_MISO_OE(oe),
		.O_MOTION_N(mot_n),
		.O_LED(led),
		.O_CAPTURE(cap),
		.O_REST_LEVEL(lvl)
	);
	osp_host osp_host_i (
		.i_clk(clk),
		.i_miso(miso),
		.i_miso_oe(oe),
		.o_sclk(sclk),
		.o_mosi(mosi),
		.o_ncs(ncs)
	);
	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Verdict and end of run
	task automatic end_sim();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_sim
	// One bounded cycle of waiting; a hang ends the run as a failure
	task automatic tick(inout int n);
		@(negedge clk);
		n++;
		if (n > 2000) begin
			n_errors++;
			end_sim();
		end
	endtask : tick
	// Register write, then the spacing writes need
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] x;
		osp_host_i.sel();
		osp_host_i.xfer({1'b1, a}, 8, x);
		osp_host_i.xfer(v, 8, x);
		osp_host_i.desel();
		repeat (3750) @(negedge clk);
	endtask : wr
	// Register read; output must be released once select is high
	task automatic rd(input logic [6:0] a, output logic [7:0] q);
		logic [7:0] x;
		osp_host_i.sel();
		osp_host_i.xfer({1'b0, a}, 8, x);
		repeat (500) @(negedge clk);
		osp_host_i.xfer(8'h00, 8, q);
		osp_host_i.desel();
		check({7'h00, oe}, 8'h00);
	endtask : rd
	// One capture result, then let the registered outputs land
	task automatic mv(input logic [7:0] dy, input logic [7:0] dx);
		frame = {dy, dx, 8'h11, 8'h22, 8'h33, 8'h44};
		fv = 1'b1;
		@(negedge clk);
		fv = 1'b0;
		@(negedge clk);
		t0 = $time;
	endtask : mv
	// Downshift moment measured from the last moved frame
	task automatic wait_lvl(input logic [1:0] k, input int dk);
		int n;
		n = 0;
		while (lvl !== k) tick(n);
		n = int'(($time - t0) / 8);
		check({7'h00, n >= dk - 4 && n <= dk + 4}, 8'h01);
	endtask : wait_lvl
	// Capture spacing and flash length over one full period
	task automatic per_chk(input int per);
		int n;
		int on;
		n = 0;
		on = 0;
		while (cap !== 1'b1) tick(n);
		n = 0;
		do begin
			if (led === 1'b1) on++;
			tick(n);
		end while (cap !== 1'b1);
		check(8'(n), 8'(per));
		check(8'(on), LED_CYC);
	endtask : per_chk
	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		ce = 1'b1;
		fv = 1'b0;
		frame = '0;
		bx = '{8'h80, 8'h02, 8'h04, 8'h11, 8'h22, 8'h33, 8'h44};
		repeat (16) @(negedge clk);
		rst = 1'b0;
		repeat (4) @(negedge clk);
		check({7'h00, oe}, 8'h00);
		check({7'h00, mot_n}, 8'h01);
		check({6'h00, lvl}, 8'h00);
		// Store and read back two registers
		wr(7'h20, 8'ha5);
		wr(7'h21, 8'h5a);
		rd(7'h20, d);
		check(d, 8'ha5);
		rd(7'h21, d);
		check(d, 8'h5a);
		// A write clocked while select is high must change nothing
		osp_host_i.xfer(8'ha0, 8, d);
		osp_host_i.xfer(8'h00, 8, d);
		rd(7'h20, d);
		check(d, 8'ha5);
		// Write cut short after five data bits is dropped
		osp_host_i.sel();
		osp_host_i.xfer(8'ha0, 8, d);
		osp_host_i.xfer(8'h00, 5, d);
		osp_host_i.desel();
		rd(7'h20, d);
		check(d, 8'ha5);
		// Still frame, moved frame, then clearing by reads
		mv(8'h00, 8'h00);
		check({7'h00, mot_n}, 8'h01);
		mv(8'h03, 8'hfe);
		check({7'h00, mot_n}, 8'h00);
		rd(ADDR_MOTION, d);
		check(d, 8'h80);
		rd(ADDR_DY, d);
		check(d, 8'h03);
		check({7'h00, mot_n}, 8'h00);
		rd(ADDR_DX, d);
		check(d, 8'hfe);
		check({7'h00, mot_n}, 8'h01);
		// Clearing by a status write
		mv(8'h00, 8'h01);
		wr(ADDR_MOTION, 8'h00);
		check({7'h00, mot_n}, 8'h01);
		rd(ADDR_DX, d);
		// Burst of accumulated deltas, then port locked until release
		mv(8'h01, 8'h02);
		mv(8'h01, 8'h02);
		osp_host_i.sel();
		osp_host_i.xfer({1'b0, ADDR_BURST}, 8, d);
		repeat (500) @(negedge clk);
		for (int i = 0; i < 7; i++) begin
			osp_host_i.xfer(8'h00, 8, d);
			check(d, bx[i]);
		end
		osp_host_i.xfer(8'ha0, 8, d);
		osp_host_i.xfer(8'h00, 8, d);
		osp_host_i.desel();
		check({7'h00, mot_n}, 8'h01);
		rd(7'h20, d);
		check(d, 8'ha5);
		// Rest levels from run down to deep rest
		mv(8'h00, 8'h01);
		check({6'h00, lvl}, 8'h00);
		per_chk(40);
		wait_lvl(2'h1, 300);
		per_chk(50);
		wait_lvl(2'h2, 600);
		per_chk(60);
		wait_lvl(2'h3, 900);
		per_chk(70);
		check({7'h00, oe}, 8'h00);
		// Enable low freezes state: a moved frame must not wake it
		ce = 1'b0;
		mv(8'h00, 8'h01);
		repeat (50) @(negedge clk);
		check({6'h00, lvl}, 8'h03);
		ce = 1'b1;
		@(negedge clk);
		mv(8'h00, 8'h01);
		check({6'h00, lvl}, 8'h00);
		end_sim();
	end
endmodule : optical_sensor_serial_port_tb
